// file: rtl/mbx_pkg.sv
package mbx_pkg;

	// ==========================================================
	// sizes
	localparam int NM = 12;
	localparam int NS = 10;
	localparam int IW = 4;
	localparam int SW = 8;
	localparam int CW = 8;

	// ==========================================================
	// slave port numbers
	localparam logic [3:0] S_SRAM = 4'h0;
	localparam logic [3:0] S_ROM = 4'h1;
	localparam logic [3:0] S_SMD = 4'h2;
	localparam logic [3:0] S_UHP = 4'h3;
	localparam logic [3:0] S_EBI = 4'h4;
	localparam logic [3:0] S_DDR1 = 4'h5;
	localparam logic [3:0] S_DDR2 = 4'h6;
	localparam logic [3:0] S_DDR3 = 4'h7;
	localparam logic [3:0] S_BR0 = 4'h8;
	localparam logic [3:0] S_BR1 = 4'h9;

	// ==========================================================
	// address regions, haddr[31:28]
	localparam logic [3:0] RGN_BOOT = 4'h0;
	localparam logic [3:0] RGN_ROM = 4'h1;
	localparam logic [3:0] RGN_SRAM = 4'h2;
	localparam logic [3:0] RGN_SMD = 4'h3;
	localparam logic [3:0] RGN_UHP = 4'h4;
	localparam logic [3:0] RGN_EBI = 4'h5;
	localparam logic [3:0] RGN_DDR1 = 4'h7;
	localparam logic [3:0] RGN_DDR2 = 4'h8;
	localparam logic [3:0] RGN_DDR3 = 4'h9;
	localparam logic [3:0] RGN_BR0 = 4'hE;
	localparam logic [3:0] RGN_BR1 = 4'hF;

	// ==========================================================
	// wired paths, one row per slave, bit m = master m
	localparam logic [NS-1:0][NM-1:0] ACCESS = {12'h03F, 12'h03F, 12'h200, 12'h032,
		12'h00D, 12'hFFF, 12'h003, 12'h033, 12'h03F, 12'hFFF};

	// ==========================================================
	// bus codes and arbiter modes
	localparam logic [1:0] HT_IDLE = 2'h0;
	localparam logic [1:0] HT_NONSEQ = 2'h2;
	localparam logic [2:0] HB_SINGLE = 3'h0;
	localparam logic [2:0] HB_INCR = 3'h1;
	localparam logic [1:0] DEF_NONE = 2'h0;
	localparam logic [1:0] DEF_LAST = 2'h1;
	localparam logic [1:0] DEF_FIXED = 2'h2;
	localparam logic [7:0] ULBT_MASK [8] = '{8'h00, 8'h00, 8'h03, 8'h07, 8'h0F, 8'h1F,
		8'h3F, 8'h7F};

	typedef enum logic [1:0] {ERR_IDLE = 2'b00, ERR_ONE = 2'b01, ERR_TWO = 2'b10} mbx_err_e;

	// {hit, slave}; a miss reports slave 0 so indexing stays in range
	function automatic logic [4:0] mbx_decode(input logic [3:0] rgn, input logic remap,
		input logic boot_ext);
		case (rgn)
			RGN_BOOT: mbx_decode = {1'b1, remap ? S_SRAM : (boot_ext ? S_EBI : S_ROM)};
			RGN_ROM: mbx_decode = {1'b1, S_ROM};
			RGN_SRAM: mbx_decode = {1'b1, S_SRAM};
			RGN_SMD: mbx_decode = {1'b1, S_SMD};
			RGN_UHP: mbx_decode = {1'b1, S_UHP};
			RGN_EBI: mbx_decode = {1'b1, S_EBI};
			RGN_DDR1: mbx_decode = {1'b1, S_DDR1};
			RGN_DDR2: mbx_decode = {1'b1, S_DDR2};
			RGN_DDR3: mbx_decode = {1'b1, S_DDR3};
			RGN_BR0: mbx_decode = {1'b1, S_BR0};
			RGN_BR1: mbx_decode = {1'b1, S_BR1};
			default: mbx_decode = {1'b0, S_SRAM};
		endcase
	endfunction

	// {limited, beat mask}: burst end when (beat+1) & mask is zero
	function automatic logic [8:0] mbx_len(input logic [2:0] burst, input logic [2:0] ulbt);
		case (burst)
			HB_SINGLE: mbx_len = {1'b1, 8'h00};
			HB_INCR: mbx_len = {ulbt != 3'h0, ULBT_MASK[ulbt]};
			3'h2, 3'h3: mbx_len = {1'b1, 8'h03};
			3'h4, 3'h5: mbx_len = {1'b1, 8'h07};
			default: mbx_len = {1'b1, 8'h0F};
		endcase
	endfunction

endpackage

// file: rtl/mbx_arbiter.sv
`timescale 1ns/1ps
module mbx_arbiter #(
	parameter int NM = 12,
	parameter int IW = 4,
	parameter int SW = 8
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// requests
	input wire logic [NM-1:0] req_i,
	input wire logic rearb_i,
	// policy
	input wire logic arb_fixed_i,
	input wire logic [1:0] def_type_i,
	input wire logic [IW-1:0] fixed_def_i,
	input wire logic [SW-1:0] slot_limit_i,
	// grant
	output logic gnt_vld_o,
	output logic [IW-1:0] gnt_idx_o,
	output logic slot_exp_o
);

	// ==========================================================
	// checks
	if (NM < 2 || NM > 16 || (1 << IW) < NM)
	begin : g_bad
		$error("arbiter size out of range");
	end

	logic gnt_vld_q;
	logic [IW-1:0] gnt_idx_q;
	logic [SW-1:0] slot_q;
	logic [IW-1:0] pick;
	logic any;

	// ==========================================================
	// selection
	always_comb
	begin
		int k;
		k = 0;
		pick = '0;
		any = 1'b0;
		for (int i = NM - 1; i >= 0; i--)
		begin
			// lowest index wins fixed; round robin starts past the last grant
			k = arb_fixed_i ? i : (int'(gnt_idx_q) + 1 + i) % NM;
			if (req_i[k])
			begin
				pick = IW'(k);
				any = 1'b1;
			end
		end
	end

	// ==========================================================
	// grant register, one cycle after arbitration
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			gnt_vld_q <= 1'b0;
			gnt_idx_q <= '0;
		end
		else if (rearb_i && any)
		begin
			gnt_vld_q <= 1'b1;
			gnt_idx_q <= pick;
		end
		else if (rearb_i)
		begin
			case (def_type_i)
				mbx_pkg::DEF_NONE: gnt_vld_q <= 1'b0;
				mbx_pkg::DEF_LAST: gnt_vld_q <= gnt_vld_q;
				mbx_pkg::DEF_FIXED:
				begin
					gnt_vld_q <= int'(fixed_def_i) < NM;
					gnt_idx_q <= int'(fixed_def_i) < NM ? fixed_def_i : gnt_idx_q;
				end
				default: gnt_vld_q <= 1'b0;
			endcase
		end
	end

	// ==========================================================
	// slot cycle limit, zero limit disables breaking
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
			slot_q <= '0;
		else if (rearb_i && any)
			slot_q <= slot_limit_i;
		else if (slot_q != '0)
			slot_q <= slot_q - SW'(1);
	end

	assign slot_exp_o = gnt_vld_q && slot_q == '0 && slot_limit_i != '0;
	assign gnt_vld_o = gnt_vld_q;
	assign gnt_idx_o = gnt_idx_q;

endmodule

// file: rtl/mbx_crossbar.sv
`timescale 1ns/1ps
module mbx_crossbar #(
	parameter int NM = 12,
	parameter int NS = 10
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// master layers
	input wire logic [NM-1:0][31:0] m_haddr_i,
	input wire logic [NM-1:0][1:0] m_htrans_i,
	input wire logic [NM-1:0] m_hwrite_i,
	input wire logic [NM-1:0][2:0] m_hsize_i,
	input wire logic [NM-1:0][2:0] m_hburst_i,
	input wire logic [NM-1:0][31:0] m_hwdata_i,
	output logic [NM-1:0] m_hready_o,
	output logic [NM-1:0] m_hresp_o,
	output logic [NM-1:0][31:0] m_hrdata_o,
	// slave ports
	output logic [NS-1:0] s_hsel_o,
	output logic [NS-1:0][31:0] s_haddr_o,
	output logic [NS-1:0][1:0] s_htrans_o,
	output logic [NS-1:0] s_hwrite_o,
	output logic [NS-1:0][2:0] s_hsize_o,
	output logic [NS-1:0][2:0] s_hburst_o,
	output logic [NS-1:0][31:0] s_hwdata_o,
	output logic [NS-1:0] s_hready_o,
	input wire logic [NS-1:0] s_hreadyout_i,
	input wire logic [NS-1:0] s_hresp_i,
	input wire logic [NS-1:0][31:0] s_hrdata_i,
	// configuration, plain inputs; the register interface sits outside
	input wire logic boot_select_nonvolatile_bit_i,
	input wire logic [NM-1:0] master_remap_control_i,
	input wire logic [NM-1:0][2:0] ulbt_i,
	input wire logic [NS-1:0] arb_fixed_i,
	input wire logic [NS-1:0][1:0] def_type_i,
	input wire logic [NS-1:0][3:0] fixed_def_i,
	input wire logic [NS-1:0][7:0] slot_limit_i
);

	// ==========================================================
	// checks
	// the path table is built for this instance only
	if (NM != mbx_pkg::NM || NS != mbx_pkg::NS || NM > 16 || NS > 16)
	begin : g_bad
		$error("crossbar size does not match path table");
	end

	// ==========================================================
	// boot strap
	logic [2:0] boot_sync_q;
	logic boot_ext_q;

	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
			boot_sync_q <= {boot_sync_q[1:0], boot_select_nonvolatile_bit_i};
		else
			boot_sync_q <= {boot_sync_q[1:0], boot_select_nonvolatile_bit_i};
	end

	// strap frozen at reset release, later pin changes ignored
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i && boot_sync_q[1] == boot_sync_q[2])
			boot_ext_q <= boot_sync_q[2];
	end

	// ==========================================================
	// shared state
	localparam int CWD = mbx_pkg::CW;

	logic [NM-1:0] acc, good, lastb, gntd, addr_ok, dp_free;
	logic [NM-1:0] dp_act_q, hold_v_q, hold_r_q;
	logic [NM-1:0][3:0] sel, dp_slv_q;
	logic [NM-1:0][CWD-1:0] cnt_q;
	logic [NM-1:0][31:0] hold_d_q;
	mbx_pkg::mbx_err_e err_q [NM];
	logic [NS-1:0][NM-1:0] req;
	logic [NS-1:0] gnt_vld, rearb, slot_exp, s_rdy, ld, sdp_vld_q;
	logic [NS-1:0][3:0] gnt_idx, sdp_own_q;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (sys_rst_i);

	// ==========================================================
	// master layers
	for (genvar m = 0; m < NM; m++)
	begin : g_m
		logic [4:0] dec;
		logic [8:0] bl;
		logic [CWD-1:0] idx;

		// same decoder in every layer, remap chosen per master
		assign dec = mbx_pkg::mbx_decode(m_haddr_i[m][31:28], master_remap_control_i[m],
			boot_ext_q);
		assign sel[m] = dec[3:0];
		assign good[m] = dec[4] && mbx_pkg::ACCESS[dec[3:0]][m];
		assign gntd[m] = gnt_vld[sel[m]] && gnt_idx[sel[m]] == 4'(m);
		// a granted default master passes in the same cycle
		assign addr_ok[m] = !m_htrans_i[m][1] || !good[m] || (gntd[m] && s_rdy[sel[m]]);
		assign dp_free[m] = !dp_act_q[m] || s_hreadyout_i[dp_slv_q[m]];
		assign m_hready_o[m] = dp_free[m] && addr_ok[m] && err_q[m] != mbx_pkg::ERR_ONE;
		assign acc[m] = m_hready_o[m] && m_htrans_i[m][1];

		assign bl = mbx_pkg::mbx_len(m_hburst_i[m], ulbt_i[m]);
		assign idx = m_htrans_i[m] == mbx_pkg::HT_NONSEQ ? '0 : cnt_q[m];
		assign lastb[m] = bl[8] && ((idx + CWD'(1)) & bl[7:0]) == '0;

		assign m_hresp_o[m] = err_q[m] != mbx_pkg::ERR_IDLE ||
			(dp_act_q[m] ? s_hresp_i[dp_slv_q[m]] : hold_v_q[m] && hold_r_q[m]);
		assign m_hrdata_o[m] = hold_v_q[m] ? hold_d_q[m] : s_hrdata_i[dp_slv_q[m]];

		for (genvar s = 0; s < NS; s++)
		begin : g_req
			assign req[s][m] = m_htrans_i[m][1] && good[m] && sel[m] == 4'(s);
		end

		always_ff @(posedge clock_i)
		begin
			if (sys_rst_i)
			begin
				dp_act_q[m] <= 1'b0;
				dp_slv_q[m] <= '0;
			end
			else if (acc[m])
			begin
				dp_act_q[m] <= good[m];
				dp_slv_q[m] <= sel[m];
			end
			else if (dp_free[m])
				dp_act_q[m] <= 1'b0;
		end

		// two-cycle error for paths that go nowhere
		always_ff @(posedge clock_i)
		begin
			if (sys_rst_i)
				err_q[m] <= mbx_pkg::ERR_IDLE;
			else
			begin
				case (err_q[m])
					mbx_pkg::ERR_ONE: err_q[m] <= mbx_pkg::ERR_TWO;
					default:
					begin
						if (acc[m] && !good[m])
							err_q[m] <= mbx_pkg::ERR_ONE;
						else if (m_hready_o[m])
							err_q[m] <= mbx_pkg::ERR_IDLE;
					end
				endcase
			end
		end

		// keeps a finished answer while the next address waits for a grant
		always_ff @(posedge clock_i)
		begin
			if (sys_rst_i)
			begin
				hold_v_q[m] <= 1'b0;
				hold_r_q[m] <= 1'b0;
				hold_d_q[m] <= '0;
			end
			else if (m_hready_o[m])
				hold_v_q[m] <= 1'b0;
			else if (dp_act_q[m] && s_hreadyout_i[dp_slv_q[m]])
			begin
				hold_v_q[m] <= 1'b1;
				hold_r_q[m] <= s_hresp_i[dp_slv_q[m]];
				hold_d_q[m] <= s_hrdata_i[dp_slv_q[m]];
			end
		end

		always_ff @(posedge clock_i)
		begin
			if (sys_rst_i)
				cnt_q[m] <= '0;
			else if (acc[m])
				cnt_q[m] <= idx + CWD'(1);
		end

		property p_err;
			acc[m] && !good[m] |=> m_hresp_o[m] && !m_hready_o[m] ##1 m_hresp_o[m];
		endproperty
		a_err: assert property (p_err) else $error("no error answer");

		property p_remap;
			m_htrans_i[m][1] && m_haddr_i[m][31:28] == mbx_pkg::RGN_BOOT &&
				master_remap_control_i[m] |-> good[m] && sel[m] == mbx_pkg::S_SRAM;
		endproperty
		a_remap: assert property (p_remap) else $error("remap not to SRAM");

		property p_boot;
			m_htrans_i[m][1] && m_haddr_i[m][31:28] == mbx_pkg::RGN_BOOT &&
				!master_remap_control_i[m] |->
				sel[m] == (boot_ext_q ? mbx_pkg::S_EBI : mbx_pkg::S_ROM);
		endproperty
		a_boot: assert property (p_boot) else $error("boot target wrong");

		property p_dp;
			acc[m] && good[m] |=> dp_act_q[m] && dp_slv_q[m] == $past(sel[m]);
		endproperty
		a_dp: assert property (p_dp) else $error("data phase lost");
	end

	// ==========================================================
	// slave ports
	for (genvar s = 0; s < NS; s++)
	begin : g_s
		logic [3:0] own;
		logic own_act;

		assign own = gnt_idx[s];
		assign s_rdy[s] = !sdp_vld_q[s] || s_hreadyout_i[s];
		assign own_act = gnt_vld[s] && req[s][own];
		assign ld[s] = own_act && m_hready_o[own];
		// rearbitrate on idle, single or burst end, or slot expiry
		assign rearb[s] = s_rdy[s] && (!own_act || (m_hready_o[own] && lastb[own]) ||
			slot_exp[s]);

		assign s_hsel_o[s] = ld[s];
		assign s_haddr_o[s] = m_haddr_i[own];
		assign s_htrans_o[s] = ld[s] ? m_htrans_i[own] : mbx_pkg::HT_IDLE;
		assign s_hwrite_o[s] = m_hwrite_i[own];
		assign s_hsize_o[s] = m_hsize_i[own];
		assign s_hburst_o[s] = m_hburst_i[own];
		assign s_hwdata_o[s] = m_hwdata_i[sdp_own_q[s]];
		assign s_hready_o[s] = s_rdy[s];

		always_ff @(posedge clock_i)
		begin
			if (sys_rst_i)
			begin
				sdp_vld_q[s] <= 1'b0;
				sdp_own_q[s] <= '0;
			end
			else if (s_rdy[s])
			begin
				sdp_vld_q[s] <= ld[s];
				sdp_own_q[s] <= own;
			end
		end

		mbx_arbiter #(
			.NM(NM),
			.IW(mbx_pkg::IW),
			.SW(mbx_pkg::SW)
		) u_arb (
			.clock_i(clock_i),
			.sys_rst_i(sys_rst_i),
			.req_i(req[s]),
			.rearb_i(rearb[s]),
			.arb_fixed_i(arb_fixed_i[s]),
			.def_type_i(def_type_i[s]),
			.fixed_def_i(fixed_def_i[s]),
			.slot_limit_i(slot_limit_i[s]),
			.gnt_vld_o(gnt_vld[s]),
			.gnt_idx_o(gnt_idx[s]),
			.slot_exp_o(slot_exp[s])
		);

		property p_path;
			s_hsel_o[s] |-> mbx_pkg::ACCESS[s][own];
		endproperty
		a_path: assert property (p_path) else $error("unwired path selected");

		property p_one;
			rearb[s] && $onehot(req[s]) |=> gnt_vld[s] && req[s][gnt_idx[s]] ||
				gnt_idx[s] == $past(gnt_idx[s]) || !$past(req[s][gnt_idx[s]]);
		endproperty
		a_one: assert property (p_one) else $error("lone request not granted");

		property p_last;
			rearb[s] && req[s] == '0 && def_type_i[s] == mbx_pkg::DEF_LAST && gnt_vld[s]
				|=> gnt_vld[s] && $stable(gnt_idx[s]);
		endproperty
		a_last: assert property (p_last) else $error("last master dropped");

		property p_none;
			rearb[s] && req[s] == '0 && def_type_i[s] == mbx_pkg::DEF_NONE |=> !gnt_vld[s];
		endproperty
		a_none: assert property (p_none) else $error("slave not released");

		property p_fixed;
			rearb[s] && req[s] == '0 && def_type_i[s] == mbx_pkg::DEF_FIXED &&
				int'(fixed_def_i[s]) < NM |=> gnt_vld[s] && gnt_idx[s] == $past(fixed_def_i[s]);
		endproperty
		a_fixed: assert property (p_fixed) else $error("fixed default missed");

		property p_hold;
			!rearb[s] |=> $stable(gnt_idx[s]) && $stable(gnt_vld[s]);
		endproperty
		a_hold: assert property (p_hold) else $error("burst broken early");
	end

	// ==========================================================
	// scenarios
	c_err: cover property (acc[0] && !good[0]);
	c_par: cover property (ld[0] && ld[4]);
	c_switch: cover property (gnt_vld[0] ##1 gnt_idx[0] != $past(gnt_idx[0]));
	c_hold: cover property (hold_v_q[1] && !m_hready_o[1]);

endmodule

// file: bench/mbx_slave_model.sv
`timescale 1ns/1ps
module mbx_slave_model #(
	parameter int NS = 10
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// slave ports
	input wire logic [NS-1:0] s_hsel_i,
	input wire logic [NS-1:0][31:0] s_haddr_i,
	input wire logic [NS-1:0][1:0] s_htrans_i,
	input wire logic [NS-1:0] s_hready_i,
	input wire logic [NS-1:0] slow_i,
	output logic [NS-1:0] s_hreadyout_o,
	output logic [NS-1:0] s_hresp_o,
	output logic [NS-1:0][31:0] s_hrdata_o
);
	logic [NS-1:0] pend_q;
	logic [NS-1:0] wait_q;
	logic [NS-1:0][27:0] addr_q;
	// ==========================================================
	// one memory-like slave per port
	for (genvar s = 0; s < NS; s++)
	begin : g_s
		always_ff @(posedge clock_i)
		begin
			if (sys_rst_i)
			begin
				pend_q[s] <= 1'b0;
				wait_q[s] <= 1'b0;
				addr_q[s] <= '0;
			end
			else if (s_hready_i[s])
			begin
				pend_q[s] <= s_hsel_i[s] & s_htrans_i[s][1];
				addr_q[s] <= s_haddr_i[s][27:0];
				wait_q[s] <= 1'b0;
			end
			else
				wait_q[s] <= 1'b1;
		end
		// slow ports add one wait state per data phase
		assign s_hreadyout_o[s] = ~pend_q[s] | ~slow_i[s] | wait_q[s];
		assign s_hresp_o[s] = 1'b0;
		// data names the port and address; inverted while not answering
		assign s_hrdata_o[s] = (pend_q[s] & s_hreadyout_o[s]) ? {4'(s), addr_q[s]} :
			~{4'(s), addr_q[s]};
	end
endmodule

// file: bench/tb_mbx_crossbar.sv
`timescale 1ns/1ps
module tb_mbx_crossbar;
	localparam int NM = mbx_pkg::NM;
	localparam int NS = mbx_pkg::NS;
	// region to slave with no remap and ROM boot, -1 unmapped
	localparam int RS [16] = '{1, 1, 0, 2, 3, 4, -1, 5, 6, 7, -1, -1, -1, -1, 8, 9};
	localparam logic [11:0] OK [10] = '{12'hFFF, 12'h03F, 12'h033, 12'h003, 12'hFFF,
		12'h00D, 12'h032, 12'h200, 12'h03F, 12'h03F};
	logic clock_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [NM-1:0][31:0] haddr = '0;
	logic [NM-1:0][1:0] htrans = '0;
	logic [NM-1:0][2:0] hburst = '0;
	logic [NM-1:0][2:0] hsize = {NM{3'h2}};
	logic [NM-1:0] hwrite = '0;
	logic [NM-1:0][31:0] hwdata = '0;
	logic strap = 1'b0;
	logic [NM-1:0] remap = '0;
	logic [NM-1:0][2:0] ulbt = '0;
	logic [NS-1:0] arb_fixed = '0;
	logic [NS-1:0][1:0] def_type = '0;
	logic [NS-1:0][3:0] fixed_def = '0;
	logic [NS-1:0][7:0] slot_limit = '0;
	logic [NS-1:0] slow = '0;
	logic [NM-1:0] m_hready;
	logic [NM-1:0] m_hresp;
	logic [NM-1:0][31:0] m_hrdata;
	logic [NS-1:0] s_hsel;
	logic [NS-1:0][31:0] s_haddr;
	logic [NS-1:0][1:0] s_htrans;
	logic [NS-1:0] s_hready;
	logic [NS-1:0] s_hreadyout;
	logic [NS-1:0] s_hresp;
	logic [NS-1:0][31:0] s_hrdata;
	int fails = 0;
	int cmp_count = 0;
	int lat_seen [NM];
	time done_t [NM];
	always #4 clock_i = ~clock_i;
	mbx_crossbar dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .m_haddr_i(haddr),
		.m_htrans_i(htrans), .m_hwrite_i(hwrite), .m_hsize_i(hsize), .m_hburst_i(hburst),
		.m_hwdata_i(hwdata), .m_hready_o(m_hready), .m_hresp_o(m_hresp),
		.m_hrdata_o(m_hrdata), .s_hsel_o(s_hsel), .s_haddr_o(s_haddr),
		.s_htrans_o(s_htrans), .s_hwrite_o(), .s_hsize_o(), .s_hburst_o(), .s_hwdata_o(),
		.s_hready_o(s_hready), .s_hreadyout_i(s_hreadyout), .s_hresp_i(s_hresp),
		.s_hrdata_i(s_hrdata), .boot_select_nonvolatile_bit_i(strap),
		.master_remap_control_i(remap), .ulbt_i(ulbt), .arb_fixed_i(arb_fixed),
		.def_type_i(def_type), .fixed_def_i(fixed_def), .slot_limit_i(slot_limit));
	mbx_slave_model #(.NS(NS)) slaves (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
		.s_hsel_i(s_hsel), .s_haddr_i(s_haddr), .s_htrans_i(s_htrans), .s_hready_i(s_hready),
		.slow_i(slow), .s_hreadyout_o(s_hreadyout), .s_hresp_o(s_hresp),
		.s_hrdata_o(s_hrdata));
	// ==========================================================
	// shared tasks
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic do_reset();
		sys_rst_i = 1'b1;
		idle(6);
		sys_rst_i = 1'b0;
	endtask
	// single read; s is the slave expected to answer, -1 for an error
	task automatic acc(input int m, input logic [31:0] a, input int s);
		int n;
		n = 0;
		haddr[m] = a;
		htrans[m] = mbx_pkg::HT_NONSEQ;
		hburst[m] = mbx_pkg::HB_SINGLE;
		@(posedge clock_i);
		while (m_hready[m] !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge clock_i);
		end
		lat_seen[m] = n;
		#1 htrans[m] = mbx_pkg::HT_IDLE;
		@(posedge clock_i);
		while (m_hready[m] !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge clock_i);
		end
		done_t[m] = $time;
		chk("hready wait", 32'h0, 32'(n >= 50));
		chk("hresp", 32'(s < 0), 32'(m_hresp[m]));
		if (s >= 0)
			chk("hrdata", {4'(s), a[27:0]}, m_hrdata[m]);
		#1;
	endtask
	// undefined-length burst of n beats, held while the grant is lost
	task automatic burst(input int m, input logic [31:0] a, input int n);
		int b;
		int w;
		b = 0;
		w = 0;
		haddr[m] = a;
		htrans[m] = mbx_pkg::HT_NONSEQ;
		hburst[m] = mbx_pkg::HB_INCR;
		while (b < n && w < 200)
		begin
			@(posedge clock_i);
			if (m_hready[m] === 1'b1)
			begin
				b++;
				#1 haddr[m] = a + 32'(4 * b);
				htrans[m] = (b < n) ? 2'h3 : mbx_pkg::HT_IDLE;
			end
			else
				w++;
		end
		@(posedge clock_i);
		while (m_hready[m] !== 1'b1 && w < 200)
		begin
			w++;
			@(posedge clock_i);
		end
		done_t[m] = $time;
		chk("burst wait", 32'h0, 32'(w >= 200));
		#1;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_map();
		int e;
		for (int m = 0; m < NM; m++)
			for (int r = 0; r < 16; r++)
			begin
				e = (RS[r] >= 0 && OK[RS[r]][m]) ? RS[r] : -1;
				acc(m, {4'(r), 24'h000000, 4'(m)}, e);
			end
	endtask
	task automatic t_default();
		int dt [8] = '{2, 2, 2, 1, 1, 1, 0, 0};
		int mm [8] = '{3, 1, 3, 5, 5, 2, 5, 5};
		int el [8] = '{0, 1, 0, 1, 0, 1, 1, 1};
		fixed_def[0] = 4'h3;
		for (int i = 0; i < 8; i++)
		begin
			def_type[0] = 2'(dt[i]);
			idle(3);
			acc(mm[i], 32'h20000100, 0);
			chk("grant latency", 32'(el[i]), 32'(lat_seen[mm[i]]));
		end
	endtask
	task automatic t_boot();
		remap[1] = 1'b1;
		idle(2);
		acc(1, 32'h00000010, 0);
		acc(0, 32'h00000010, 1);
		remap[1] = 1'b0;
		idle(2);
		acc(1, 32'h00000010, 1);
		strap = 1'b1;
		do_reset();
		strap = 1'b0;
		acc(0, 32'h00000020, 4);
		acc(6, 32'h00000020, 4);
		do_reset();
		acc(6, 32'h00000020, -1);
	endtask
	task automatic t_arb();
		logic [3:0] w;
		fork
			acc(0, 32'h20000000, 0);
			acc(2, 32'h50000000, 4);
		join
		chk("parallel finish", 32'h1, 32'(done_t[0] == done_t[2]));
		for (int k = 0; k < 4; k++)
		begin
			arb_fixed[0] = (k < 2);
			idle(2);
			// lone access makes master 2 the last winner, so 4 takes the next turn
			if (k == 3)
				acc(2, 32'h20000040, 0);
			fork
				acc(2, 32'h20000040, 0);
				acc(4, 32'h20000080, 0);
			join
			w[k] = done_t[4] < done_t[2];
		end
		chk("fixed winner", 32'h0, 32'(w[1:0]));
		chk("round robin turns", 32'h1, 32'(w[2] != w[3]));
	endtask
	task automatic t_break();
		logic [2:0] lb [3] = '{3'h1, 3'h0, 3'h0};
		logic [7:0] sl [3] = '{8'h00, 8'h00, 8'h02};
		int early [3] = '{1, 0, 1};
		arb_fixed[0] = 1'b0;
		for (int c = 0; c < 3; c++)
		begin
			ulbt[2] = lb[c];
			slot_limit[0] = sl[c];
			slow[0] = (c == 2);
			idle(2);
			fork
				burst(2, 32'h20000200, 8);
				begin
					idle(2);
					acc(4, 32'h20000300, 0);
				end
			join
			chk("burst broken", 32'(early[c]), 32'(done_t[4] < done_t[2]));
		end
	endtask
	// ==========================================================
	// main sequence and watchdog
	initial
	begin
		#1;
		do_reset();
		t_map();
		t_default();
		t_boot();
		t_arb();
		t_break();
		give_verdict();
	end
	initial
	begin
		#400000;
		fails++;
		$display("mismatch watchdog expected finish seen hang");
		give_verdict();
	end
endmodule
